// File: src/obcd_loader.sv
/*
 * Option byte configuration decoder: reads the five option bytes from
 * nonvolatile storage after reset, decodes them and registers the
 * protection, watchdog and oscillator settings, then releases the cpu.
 * Assumes the storage answers each read strobe with an ack pulse and
 * data on the same clock, and that the cpu is held while cpu release
 * is low.
 */
`timescale 1ns/100ps
`default_nettype none
`include "obcd_consts.svh"

module obcd_loader
    import obcd_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            ce,
    input  wire logic            nvm_ack,
    input  wire obcd_byte_type   nvm_rdata,
    output var  logic            nvm_rd_reg,
    output var  logic [2:0]      nvm_addr_reg,
    output var  logic            config_valid_reg,
    output var  logic            cpu_release_reg,
    output var  logic            readout_lock_reg,
    output var  obcd_byte_type   boot_area_pages_reg,
    output var  logic            boot_vector_only_reg,
    output var  logic            boot_read_protect_reg,
    output var  logic            boot_write_protect_reg,
    output var  logic            indep_wdog_auto_start_reg,
    output var  logic            indep_wdog_sleep_freeze_reg,
    output var  logic            window_wdog_auto_start_reg,
    output var  logic            window_wdog_sleep_reset_reg,
    output var  obcd_settle_type fast_xtal_settle_count_reg,
    output var  obcd_settle_type slow_xtal_settle_count_reg
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    obcd_load_state_type state_reg;
    obcd_load_state_type state_next;
    obcd_byte_type       opt_mem_reg [0:4];
    obcd_byte_type       opt_mem_next [0:4];
    logic [2:0]          idx_reg;
    logic [2:0]          idx_next;
    logic                rd_next;
    logic                valid_next;
    logic                release_next;
    logic                lock_next;
    obcd_byte_type       pages_next;
    logic                vec_next;
    logic                rprot_next;
    logic                wprot_next;
    logic                iwdg_auto_next;
    logic                iwdg_frz_next;
    logic                wwdg_auto_next;
    logic                wwdg_rst_next;
    obcd_settle_type     fast_next;
    obcd_settle_type     slow_next;
    obcd_byte_type       boot_pages;
    logic                boot_vec;
    logic                boot_rprot;
    logic                boot_wprot;
    obcd_settle_type     fast_cycles;
    obcd_settle_type     slow_cycles;
    obcd_byte_type       wdog_byte;
    obcd_byte_type       slow_byte;

    assign wdog_byte = opt_mem_reg[`OBCD_IDX_WDOG];
    assign slow_byte = opt_mem_reg[`OBCD_IDX_SLOW];

    ////////////////////////////////////////////////////////////////////
    // decoders

    obcd_boot_decode u_boot (
        .size          (opt_mem_reg[`OBCD_IDX_BOOT]),
        .pages         (boot_pages),
        .vector_only   (boot_vec),
        .read_protect  (boot_rprot),
        .write_protect (boot_wprot)
    );

    obcd_settle_decode u_fast (
        .code   (wdog_byte[`OBCD_FAST_CNT_MSB:`OBCD_FAST_CNT_LSB]),
        .cycles (fast_cycles)
    );

    obcd_settle_decode u_slow (
        .code   (slow_byte[`OBCD_SLOW_CNT_MSB:`OBCD_SLOW_CNT_LSB]),
        .cycles (slow_cycles)
    );

    ////////////////////////////////////////////////////////////////////
    // load sequencer and decoded settings

    always_comb begin
        state_next     = state_reg;
        idx_next       = idx_reg;
        rd_next        = 1'b0;
        valid_next     = config_valid_reg;
        release_next   = cpu_release_reg;
        lock_next      = readout_lock_reg;
        pages_next     = boot_area_pages_reg;
        vec_next       = boot_vector_only_reg;
        rprot_next     = boot_read_protect_reg;
        wprot_next     = boot_write_protect_reg;
        iwdg_auto_next = indep_wdog_auto_start_reg;
        iwdg_frz_next  = indep_wdog_sleep_freeze_reg;
        wwdg_auto_next = window_wdog_auto_start_reg;
        wwdg_rst_next  = window_wdog_sleep_reset_reg;
        fast_next      = fast_xtal_settle_count_reg;
        slow_next      = slow_xtal_settle_count_reg;
        for (int i = 0; i < 5; i++) begin
            opt_mem_next[i] = opt_mem_reg[i];
        end
        case (state_reg)
            OBCD_LD_IDLE: begin
                // first read strobe goes out one cycle after release
                rd_next    = 1'b1;
                idx_next   = `OBCD_IDX_LOCK;
                state_next = OBCD_LD_WAIT;
            end
            OBCD_LD_WAIT: begin
                // acks outside this state are ignored
                if (nvm_ack) begin
                    opt_mem_next[idx_reg] = nvm_rdata;
                    if (idx_reg == `OBCD_IDX_LAST) begin
                        state_next = OBCD_LD_DECODE;
                    end else begin
                        idx_next = idx_reg + 3'h1;
                        rd_next  = 1'b1;
                    end
                end
            end
            OBCD_LD_DECODE: begin
                lock_next = (opt_mem_reg[`OBCD_IDX_LOCK]
                             != `OBCD_LOCK_OPEN);
                pages_next = boot_pages;
                vec_next   = boot_vec;
                rprot_next = boot_rprot;
                wprot_next = boot_wprot;
                iwdg_auto_next = wdog_byte[`OBCD_IWDG_AUTO_POS];
                iwdg_frz_next  = wdog_byte[`OBCD_IWDG_FRZ_POS];
                wwdg_auto_next = wdog_byte[`OBCD_WWDG_AUTO_POS];
                wwdg_rst_next  = wdog_byte[`OBCD_WWDG_RST_POS];
                fast_next  = fast_cycles;
                slow_next  = slow_cycles;
                valid_next = 1'b1;
                state_next = OBCD_LD_DONE;
            end
            default: begin
                // settings stand one cycle before the cpu is let go
                release_next = config_valid_reg;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg                   <= OBCD_LD_IDLE;
            idx_reg                     <= `OBCD_IDX_LOCK;
            nvm_rd_reg                  <= 1'b0;
            nvm_addr_reg                <= `OBCD_IDX_LOCK;
            config_valid_reg            <= 1'b0;
            cpu_release_reg             <= 1'b0;
            readout_lock_reg            <= `OBCD_LOCK_RST;
            boot_area_pages_reg         <= `OBCD_PAGES_RST;
            boot_vector_only_reg        <= 1'b0;
            boot_read_protect_reg       <= 1'b0;
            boot_write_protect_reg      <= 1'b0;
            indep_wdog_auto_start_reg   <= 1'b0;
            indep_wdog_sleep_freeze_reg <= 1'b0;
            window_wdog_auto_start_reg  <= 1'b0;
            window_wdog_sleep_reset_reg <= 1'b0;
            fast_xtal_settle_count_reg  <= `OBCD_SETTLE_N0;
            slow_xtal_settle_count_reg  <= `OBCD_SETTLE_N0;
            for (int i = 0; i < 5; i++) begin
                opt_mem_reg[i] <= `OBCD_BYTE_RST;
            end
        end else if (ce) begin
            state_reg                   <= state_next;
            idx_reg                     <= idx_next;
            nvm_rd_reg                  <= rd_next;
            nvm_addr_reg                <= idx_next;
            config_valid_reg            <= valid_next;
            cpu_release_reg             <= release_next;
            readout_lock_reg            <= lock_next;
            boot_area_pages_reg         <= pages_next;
            boot_vector_only_reg        <= vec_next;
            boot_read_protect_reg       <= rprot_next;
            boot_write_protect_reg      <= wprot_next;
            indep_wdog_auto_start_reg   <= iwdg_auto_next;
            indep_wdog_sleep_freeze_reg <= iwdg_frz_next;
            window_wdog_auto_start_reg  <= wwdg_auto_next;
            window_wdog_sleep_reset_reg <= wwdg_rst_next;
            fast_xtal_settle_count_reg  <= fast_next;
            slow_xtal_settle_count_reg  <= slow_next;
            for (int i = 0; i < 5; i++) begin
                opt_mem_reg[i] <= opt_mem_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions

    obcd_byte_type boot_size;
    logic [1:0]    fast_code;
    logic [1:0]    slow_code;
    assign boot_size = opt_mem_reg[`OBCD_IDX_BOOT];
    assign fast_code = wdog_byte[`OBCD_FAST_CNT_MSB:`OBCD_FAST_CNT_LSB];
    assign slow_code = slow_byte[`OBCD_SLOW_CNT_MSB:`OBCD_SLOW_CNT_LSB];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_lock_only_open;
        config_valid_reg |-> readout_lock_reg ==
            (opt_mem_reg[`OBCD_IDX_LOCK] != `OBCD_LOCK_OPEN);
    endproperty
    a_lock_only_open: assert property (p_lock_only_open)
        else $error("readout lock disagrees with protect byte");

    property p_vectors_only;
        config_valid_reg && boot_size == `OBCD_BOOT_VECTORS |->
            boot_vector_only_reg && boot_area_pages_reg == 8'h01
            && !boot_write_protect_reg;
    endproperty
    a_vectors_only: assert property (p_vectors_only)
        else $error("size 01 must give vector-only area");

    property p_no_area;
        config_valid_reg && boot_size == `OBCD_BOOT_NONE |->
            boot_area_pages_reg == 8'h00 && !boot_write_protect_reg
            && !boot_read_protect_reg && !boot_vector_only_reg;
    endproperty
    a_no_area: assert property (p_no_area)
        else $error("size 00 must reserve no area");

    property p_two_pages;
        config_valid_reg && boot_size == `OBCD_BOOT_RW_PROT |->
            boot_area_pages_reg == 8'h02 && boot_read_protect_reg
            && boot_write_protect_reg;
    endproperty
    a_two_pages: assert property (p_two_pages)
        else $error("size 02 must read and write protect two pages");

    property p_three_pages;
        config_valid_reg && boot_size == 8'h03 |->
            boot_area_pages_reg == 8'h03 && boot_write_protect_reg
            && !boot_read_protect_reg;
    endproperty
    a_three_pages: assert property (p_three_pages)
        else $error("size 03 must write protect three pages");

    property p_full_area;
        config_valid_reg && boot_size == 8'hFF |->
            boot_area_pages_reg == 8'hFF && boot_write_protect_reg;
    endproperty
    a_full_area: assert property (p_full_area)
        else $error("size FF must write protect 255 pages");

    property p_mid_area;
        config_valid_reg && boot_size > 8'h02 |->
            boot_area_pages_reg == boot_size && boot_write_protect_reg;
    endproperty
    a_mid_area: assert property (p_mid_area)
        else $error("size N must write protect N pages");

    property p_watchdogs;
        config_valid_reg |->
            indep_wdog_auto_start_reg == wdog_byte[`OBCD_IWDG_AUTO_POS]
            && indep_wdog_sleep_freeze_reg == wdog_byte[`OBCD_IWDG_FRZ_POS]
            && window_wdog_auto_start_reg == wdog_byte[`OBCD_WWDG_AUTO_POS]
            && window_wdog_sleep_reset_reg == wdog_byte[`OBCD_WWDG_RST_POS];
    endproperty
    a_watchdogs: assert property (p_watchdogs)
        else $error("watchdog settings disagree with option byte");

    property p_fast_settle;
        config_valid_reg |-> fast_xtal_settle_count_reg ==
            (fast_code == 2'h0 ? 13'h0001 : fast_code == 2'h1 ? 13'h0010 :
             fast_code == 2'h2 ? 13'h0200 : 13'h1000);
    endproperty
    a_fast_settle: assert property (p_fast_settle)
        else $error("fast settle count wrong for its code");

    property p_slow_settle;
        config_valid_reg |-> slow_xtal_settle_count_reg ==
            (slow_code == 2'h0 ? 13'h0001 : slow_code == 2'h1 ? 13'h0010 :
             slow_code == 2'h2 ? 13'h0200 : 13'h1000);
    endproperty
    a_slow_settle: assert property (p_slow_settle)
        else $error("slow settle count wrong for its code");

    property p_release_after_valid;
        $rose(cpu_release_reg) |-> $past(config_valid_reg)
            && state_reg == OBCD_LD_DONE;
    endproperty
    a_release_after_valid: assert property (p_release_after_valid)
        else $error("cpu released before settings were valid");

    property p_locked_until_valid;
        !config_valid_reg |-> readout_lock_reg && !cpu_release_reg;
    endproperty
    a_locked_until_valid: assert property (p_locked_until_valid)
        else $error("lock or release wrong before load finished");

    property p_last_ack_decodes;
        ce && state_reg == OBCD_LD_WAIT && nvm_ack
            && idx_reg == `OBCD_IDX_LAST
        ##1 ce [*2] |-> config_valid_reg;
    endproperty
    a_last_ack_decodes: assert property (p_last_ack_decodes)
        else $error("settings not valid two cycles after last byte");

    c_open_part: cover property (
        config_valid_reg && !readout_lock_reg);
    c_rw_area: cover property (
        config_valid_reg && boot_read_protect_reg);
    c_long_settle: cover property (
        config_valid_reg && fast_xtal_settle_count_reg == 13'h1000);
    c_release: cover property ($rose(cpu_release_reg));

endmodule // obcd_loader
`default_nettype wire

// File: src/obcd_consts.svh
/*
 * Constants for the option byte configuration decoder: byte indices,
 * field positions, encodings, reset values and settle counts.
 * Assumes it is included by bare name from the decoder's source files.
 */
`ifndef OBCD_CONSTS_SVH
`define OBCD_CONSTS_SVH

// option storage indices, read in this order
`define OBCD_IDX_LOCK       3'h0
`define OBCD_IDX_BOOT       3'h1
`define OBCD_IDX_SPARE      3'h2
`define OBCD_IDX_WDOG       3'h3
`define OBCD_IDX_SLOW       3'h4
`define OBCD_IDX_LAST       3'h4

// readout protection byte value that opens the part
`define OBCD_LOCK_OPEN      8'hAA

// boot area size encodings with special meaning
`define OBCD_BOOT_NONE      8'h00
`define OBCD_BOOT_VECTORS   8'h01
`define OBCD_BOOT_RW_PROT   8'h02

// field positions in the watchdog and fast oscillator byte
`define OBCD_IWDG_AUTO_BIT  3
`define OBCD_IWDG_AUTO_POS  0
`define OBCD_IWDG_FRZ_POS   1
`define OBCD_WWDG_AUTO_POS  2
`define OBCD_WWDG_RST_POS   3
`define OBCD_FAST_CNT_LSB   4
`define OBCD_FAST_CNT_MSB   5
// field position in the slow oscillator byte
`define OBCD_SLOW_CNT_LSB   0
`define OBCD_SLOW_CNT_MSB   1

// settle field codes and oscillator cycle counts
`define OBCD_SETTLE_C0      2'h0
`define OBCD_SETTLE_C1      2'h1
`define OBCD_SETTLE_C2      2'h2
`define OBCD_SETTLE_C3      2'h3
`define OBCD_SETTLE_N0      13'h0001
`define OBCD_SETTLE_N1      13'h0010
`define OBCD_SETTLE_N2      13'h0200
`define OBCD_SETTLE_N3      13'h1000

// reset values of decoded outputs and of the stored option bytes
`define OBCD_LOCK_RST       1'b1
`define OBCD_PAGES_RST      8'h00
`define OBCD_BYTE_RST       8'h00

`endif

// File: src/obcd_pkg.sv
/*
 * Types shared by the option byte configuration decoder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package obcd_pkg;

    typedef logic [7:0]  obcd_byte_type;
    typedef logic [12:0] obcd_settle_type;

    typedef enum logic [1:0] {
        OBCD_LD_IDLE   = 2'b00,
        OBCD_LD_WAIT   = 2'b01,
        OBCD_LD_DECODE = 2'b10,
        OBCD_LD_DONE   = 2'b11
    } obcd_load_state_type;

endpackage

// File: src/obcd_settle_decode.sv
/*
 * Maps a two-bit oscillator settle code to its count of oscillator
 * cycles. Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
`default_nettype none
`include "obcd_consts.svh"

module obcd_settle_decode
    import obcd_pkg::*;
(
    input  wire logic [1:0]      code,
    output var  obcd_settle_type cycles
);

    always_comb begin
        case (code)
            `OBCD_SETTLE_C0: cycles = `OBCD_SETTLE_N0;
            `OBCD_SETTLE_C1: cycles = `OBCD_SETTLE_N1;
            `OBCD_SETTLE_C2: cycles = `OBCD_SETTLE_N2;
            default:         cycles = `OBCD_SETTLE_N3;
        endcase
    end

endmodule // obcd_settle_decode
`default_nettype wire

// File: src/obcd_boot_decode.sv
/*
 * Decodes the boot area size byte into page count and protection.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
`default_nettype none
`include "obcd_consts.svh"

module obcd_boot_decode
    import obcd_pkg::*;
(
    input  wire obcd_byte_type size,
    output var  obcd_byte_type pages,
    output var  logic          vector_only,
    output var  logic          read_protect,
    output var  logic          write_protect
);

    always_comb begin
        // every encoding reserves pages 0 to size-1
        pages         = size;
        vector_only   = 1'b0;
        read_protect  = 1'b0;
        write_protect = 1'b0;
        if (size == `OBCD_BOOT_NONE) begin
            pages = `OBCD_PAGES_RST;
        end else if (size == `OBCD_BOOT_VECTORS) begin
            vector_only = 1'b1;
        end else if (size == `OBCD_BOOT_RW_PROT) begin
            read_protect  = 1'b1;
            write_protect = 1'b1;
        end else begin
            write_protect = 1'b1;
        end
    end

endmodule // obcd_boot_decode
`default_nettype wire

// File: testbench/obcd_nvm_model.sv
/*
 * Behavioural option storage for the decoder bench: answers each
 * clock-enabled read strobe with an ack carrying the addressed byte.
 * Assumes it shares the decoder's clock, reset and clock enable.
 */
`timescale 1ns/100ps
`default_nettype none

module obcd_nvm_model
    import obcd_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          nvm_rd,
    input  wire logic [2:0]    nvm_addr,
    input  wire logic [39:0]   image,
    input  wire logic [1:0]    dly,
    output var  logic          nvm_ack,
    output var  obcd_byte_type nvm_rdata
);
    logic [2:0] idx;

    initial begin
        nvm_ack   = 1'b0;
        nvm_rdata = 8'h5A;
    end

    always begin : serve
        @(posedge clk);
        if (resetn && ce && nvm_rd) begin
            idx = nvm_addr;
            repeat (dly) @(posedge clk);
            @(negedge clk);
            nvm_ack   = 1'b1;
            nvm_rdata = image[idx*8 +: 8];
            // ack waits for an enabled edge, or the answer would be lost
            do @(posedge clk); while (!ce);
            @(negedge clk);
            nvm_ack   = 1'b0;
            // released data must not look like a valid byte
            nvm_rdata = ~nvm_rdata;
        end
    end

    always @(negedge resetn) begin
        disable serve;
        nvm_ack = 1'b0;
    end
endmodule // obcd_nvm_model

`default_nettype wire

// File: testbench/option_byte_config_decoder_tb.sv
/*
 * Self-checking bench for the option byte decoder: random and corner
 * option images, storage latency, clock-enable stalls, mid-load reset.
 * Assumes the storage model beside it and the decoder's package.
 */
`timescale 1ns/100ps
`default_nettype none

module option_byte_config_decoder_tb import obcd_pkg::*; ;
    // starting at 0 avoids a stray falling edge at time zero
    logic            clk = 1'b0;
    logic            resetn, ce, nvm_ack, nvm_rd_reg;
    obcd_byte_type   nvm_rdata, boot_area_pages_reg;
    logic [2:0]      nvm_addr_reg, idx_seen;
    logic            config_valid_reg, cpu_release_reg, readout_lock_reg;
    logic            boot_vector_only_reg, boot_read_protect_reg;
    logic            boot_write_protect_reg, indep_wdog_auto_start_reg;
    logic            indep_wdog_sleep_freeze_reg, window_wdog_auto_start_reg;
    logic            window_wdog_sleep_reset_reg;
    obcd_settle_type fast_xtal_settle_count_reg, slow_xtal_settle_count_reg;
    logic [39:0]     image;
    logic [1:0]      dly;
    logic [31:0]     seed = 32'h4EB2;
    int              n_fail = 0;
    int              checks_done = 0;

    obcd_loader dut (.clk, .resetn, .ce, .nvm_ack, .nvm_rdata, .nvm_rd_reg,
        .nvm_addr_reg, .config_valid_reg, .cpu_release_reg, .readout_lock_reg,
        .boot_area_pages_reg, .boot_vector_only_reg, .boot_read_protect_reg,
        .boot_write_protect_reg, .indep_wdog_auto_start_reg,
        .indep_wdog_sleep_freeze_reg, .window_wdog_auto_start_reg,
        .window_wdog_sleep_reset_reg, .fast_xtal_settle_count_reg,
        .slow_xtal_settle_count_reg);

    obcd_nvm_model storage (.clk, .resetn, .ce, .nvm_rd(nvm_rd_reg),
        .nvm_addr(nvm_addr_reg), .image, .dly, .nvm_ack, .nvm_rdata);

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic obcd_settle_type exp_settle(input logic [1:0] c);
        case (c)
            2'h0: return 13'h0001;
            2'h1: return 13'h0010;
            2'h2: return 13'h0200;
            default: return 13'h1000;
        endcase
    endfunction

    function automatic void rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reads must come in index order, one per accepted strobe
    always @(posedge clk) begin
        if (resetn && ce && nvm_rd_reg) begin
            chk(nvm_addr_reg, idx_seen);
            idx_seen <= idx_seen + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        ce = 1'b1;
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        chk(config_valid_reg, 1'b0);
        chk(cpu_release_reg, 1'b0);
        chk(readout_lock_reg, 1'b1);
        chk(boot_area_pages_reg, 8'h00);
        chk(fast_xtal_settle_count_reg, 13'h0001);
        chk(slow_xtal_settle_count_reg, 13'h0001);
        idx_seen = 3'h0;
        resetn = 1'b1;
    endtask

    task automatic do_run(input logic [39:0] img, input int abort_at,
                          input logic stall);
        logic v_q, ce_q;
        logic [7:0] b1;
        v_q = 1'b0;
        ce_q = 1'b1;
        b1 = img[15:8];
        image = img;
        do_reset();
        for (int n = 0; n < 600 && cpu_release_reg !== 1'b1; n++) begin
            @(negedge clk);
            if (v_q && ce_q)
                chk(cpu_release_reg, 1'b1);
            chk(cpu_release_reg & ~config_valid_reg, 1'b0);
            if (config_valid_reg === 1'b1 && !v_q)
                chk(idx_seen, 3'h5);
            v_q = config_valid_reg;
            rnd();
            ce = stall ? (seed[2:0] != 3'h0) : 1'b1;
            if (n == abort_at) begin
                do_reset();
                v_q = 1'b0;
            end
            ce_q = ce;
        end
        if (cpu_release_reg !== 1'b1) begin
            chk(cpu_release_reg, 1'b1);
            results();
        end
        chk(readout_lock_reg, img[7:0] !== 8'hAA);
        chk(boot_area_pages_reg, b1);
        chk(boot_vector_only_reg, b1 == 8'h01);
        chk(boot_read_protect_reg, b1 == 8'h02);
        chk(boot_write_protect_reg, b1 >= 8'h02);
        chk(indep_wdog_auto_start_reg, img[24]);
        chk(indep_wdog_sleep_freeze_reg, img[25]);
        chk(window_wdog_auto_start_reg, img[26]);
        chk(window_wdog_sleep_reset_reg, img[27]);
        chk(fast_xtal_settle_count_reg, exp_settle(img[29:28]));
        chk(slow_xtal_settle_count_reg, exp_settle(img[33:32]));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  boot_tab [6];
        logic [39:0] img;
        boot_tab = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF, 8'h80};
        resetn = 1'b0;
        ce = 1'b1;
        image = 40'h00_0000_0000;
        dly = 2'h0;
        idx_seen = 3'h0;
        for (int r = 0; r < 16; r++) begin
            rnd();
            img = {seed, seed[23:16]};
            if (r < 6)
                img[15:8] = boot_tab[r];
            if (r % 3 == 0)
                img[7:0] = 8'hAA;
            if (r == 1)
                img[7:0] = 8'hAB;
            img[29:28] = r[1:0];
            img[33:32] = r[3:2];
            dly = seed[9:8];
            do_run(img, (r == 7) ? 6 : -1, r > 9);
            $display("run %0d done", r);
        end
        results();
    end
endmodule // option_byte_config_decoder_tb

`default_nettype wire
